//--- core/csrc_pkg.sv
// Constants, register map and carrier types for the colour sensor register block.
// Assumes a host that writes and reads one byte register at a time by address.
// Summary of operation
// RULE1 - capture-sensor trigger reads all four channels
// RULE2 - capture-offset trigger stores fresh offset readings
// RULE3 - external clock select switches to external clock
// RULE4 - configuration readback shows external clock in use
// RULE5 - sleep bit sleeps device under external clock
// RULE6 - offset trim subtracts stored offset from results
// RULE7 - lamp pin control lets sleep pin drive lamp; code lets the pin drive it only while external clock is selected
// RULE8 - lamp-on bit switches lamp on, clear off
// RULE9 - four gain capacitor fields, values 0 to 15
// RULE10 - four integration fields, values 0 to 4095
// RULE11 - control bits are active high
// RULE12 - all setup, offset, output registers read back
// RULE13 - host sweeps integration time during white calibration
// RULE14 - host gives address to read, address+data to write
// RULE15 - otherwise run from internal 26MHz oscillator; code counts one slot per system clock (CLK_HZ, 10MHz) instead
// RULE16 - trigger bits self-clear when capture completes
package csrc_pkg;

    localparam int NUM_CHAN = 4;
    localparam int CAP_W = 4;
    localparam int INT_W = 12;
    localparam int DATA_W = 10;
    localparam int OFS_W = 8;

    localparam int CLK_HZ = 10_000_000;
    localparam int INT_OSC_HZ = 26_000_000;

    // register byte addresses
    localparam logic [7:0] ADDR_TRIGGER = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_LAMP = 8'h02;
    localparam logic [7:0] ADDR_CAP_BASE = 8'h06;
    localparam logic [7:0] ADDR_INT_BASE = 8'h0A;
    localparam logic [7:0] ADDR_OUT_BASE = 8'h40;
    localparam logic [7:0] ADDR_OFS_BASE = 8'h48;

    // field positions
    localparam int BIT_SENSOR_TRIG = 0;
    localparam int BIT_OFFSET_TRIG = 1;
    localparam int BIT_OFFSET_TRIM = 0;
    localparam int BIT_SLEEP = 1;
    localparam int BIT_EXT_CLK = 2;
    localparam int BIT_LAMP_ON = 0;
    localparam int BIT_LAMP_PIN_EN = 1;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [CAP_W-1:0] RST_CAP = 4'h0;
    localparam logic [INT_W-1:0] RST_INT = 12'h000;
    localparam logic [DATA_W-1:0] RST_DATA = 10'h000;
    localparam logic [OFS_W-1:0] RST_OFS = 8'h00;
    localparam logic [OFS_W-1:0] OFS_MAX = 8'hFF;

    typedef logic [1:0] csrc_chan_t;

    typedef enum logic [1:0] {
        CSRC_IDLE = 2'b00,
        CSRC_INTEG = 2'b01,
        CSRC_SAMPLE = 2'b11,
        CSRC_NEXT = 2'b10
    } csrc_state_e;

    // drive toward the converter front end
    typedef struct packed {
        csrc_chan_t chan;
        logic [CAP_W-1:0] gain_caps;
        logic integrating;
        logic dark;
    } csrc_front_s;

    localparam csrc_front_s RST_FRONT = '0;

endpackage : csrc_pkg

//--- core/csrc_top.sv
// Register file and capture sequencer for a four-channel colour light sensor.
// Assumes the converter front end delivers a settled sample on i_light_sample
// for the channel named on o_front, and all inputs are synchronous to i_clk.
`timescale 1ns/100ps

module csrc_top
    import csrc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_ext_clk,
    input wire logic i_sleep_pin,
    input wire logic [DATA_W-1:0] i_light_sample,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_use_ext_clk,
    output logic o_sleep,
    output logic o_lamp,
    output logic o_busy,
    output csrc_front_s o_front
);

    function automatic logic [DATA_W-1:0] sat_sub(input logic [DATA_W-1:0] a,
                                                   input logic [OFS_W-1:0] b);
        logic [DATA_W-1:0] bw;
        bw = {{(DATA_W - OFS_W){1'b0}}, b};
        sat_sub = (a > bw) ? (a - bw) : RST_DATA;
    endfunction : sat_sub

    function automatic logic [OFS_W-1:0] sat_ofs(input logic [DATA_W-1:0] a);
        sat_ofs = (a > {{(DATA_W - OFS_W){1'b0}}, OFS_MAX}) ? OFS_MAX : a[OFS_W-1:0];
    endfunction : sat_ofs

    // register decode shared by the write and read paths
    function automatic logic is_cap_addr(input logic [7:0] a, input int idx);
        is_cap_addr = (a == ADDR_CAP_BASE + 8'(idx));
    endfunction : is_cap_addr

    function automatic logic is_int_lo_addr(input logic [7:0] a, input int idx);
        is_int_lo_addr = (a == ADDR_INT_BASE + 8'(2 * idx));
    endfunction : is_int_lo_addr

    function automatic logic is_int_hi_addr(input logic [7:0] a, input int idx);
        is_int_hi_addr = (a == ADDR_INT_BASE + 8'(2 * idx + 1));
    endfunction : is_int_hi_addr

    function automatic logic is_out_lo_addr(input logic [7:0] a, input int idx);
        is_out_lo_addr = (a == ADDR_OUT_BASE + 8'(2 * idx));
    endfunction : is_out_lo_addr

    function automatic logic is_out_hi_addr(input logic [7:0] a, input int idx);
        is_out_hi_addr = (a == ADDR_OUT_BASE + 8'(2 * idx + 1));
    endfunction : is_out_hi_addr

    function automatic logic is_ofs_addr(input logic [7:0] a, input int idx);
        is_ofs_addr = (a == ADDR_OFS_BASE + 8'(idx));
    endfunction : is_ofs_addr

    function automatic logic is_last_chan(input csrc_chan_t c);
        is_last_chan = (c == csrc_chan_t'(NUM_CHAN - 1));
    endfunction : is_last_chan

    logic [7:0] config_r;
    logic [7:0] lamp_r;
    logic [1:0] trig_r;
    logic [1:0] trig_set;
    logic [1:0] trig_clr;
    logic [CAP_W-1:0] cap_r [NUM_CHAN];
    logic [INT_W-1:0] int_r [NUM_CHAN];
    logic [DATA_W-1:0] out_r [NUM_CHAN];
    logic [OFS_W-1:0] ofs_r [NUM_CHAN];
    csrc_state_e state_r;
    csrc_state_e state_nxt;
    csrc_chan_t chan_r;
    csrc_chan_t chan_nxt;
    logic mode_ofs_r;
    logic mode_ofs_nxt;
    logic [INT_W-1:0] slot_cnt_r;
    logic ext_clk_d_r;
    logic slot_tick;
    logic ext_sel;
    logic sleeping;
    logic [7:0] rdata_nxt;

    assign ext_sel = config_r[BIT_EXT_CLK];
    assign sleeping = config_r[BIT_SLEEP] & ext_sel; // RULE5
    // internal oscillator slots are taken as one per system clock
    assign slot_tick = ext_sel ? (i_ext_clk & ~ext_clk_d_r) : 1'b1; // RULE3 RULE15

    // configuration register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            config_r <= RST_BYTE;
        end else if (i_ce && i_reg_wr && i_reg_addr == ADDR_CONFIG) begin
            // reserved bits stay zero
            config_r <= '0;
            config_r[BIT_EXT_CLK] <= i_reg_wdata[BIT_EXT_CLK]; // RULE11
            config_r[BIT_SLEEP] <= i_reg_wdata[BIT_SLEEP];
            config_r[BIT_OFFSET_TRIM] <= i_reg_wdata[BIT_OFFSET_TRIM];
        end
    end

    // lamp register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            lamp_r <= RST_BYTE;
        end else if (i_ce && i_reg_wr && i_reg_addr == ADDR_LAMP) begin
            lamp_r <= '0;
            lamp_r[BIT_LAMP_ON] <= i_reg_wdata[BIT_LAMP_ON];
            lamp_r[BIT_LAMP_PIN_EN] <= i_reg_wdata[BIT_LAMP_PIN_EN];
        end
    end

    // gain capacitor counts
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                cap_r[i] <= RST_CAP;
            end
        end else if (i_ce && i_reg_wr) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (is_cap_addr(i_reg_addr, i)) begin
                    cap_r[i] <= i_reg_wdata[CAP_W-1:0]; // RULE9
                end
            end
        end
    end

    // integration slot counts; low byte then high nibble, written independently
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                int_r[i] <= RST_INT;
            end
        end else if (i_ce && i_reg_wr) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (is_int_lo_addr(i_reg_addr, i)) begin
                    int_r[i][7:0] <= i_reg_wdata; // RULE10
                end
                if (is_int_hi_addr(i_reg_addr, i)) begin
                    int_r[i][INT_W-1:8] <= i_reg_wdata[INT_W-9:0]; // RULE10
                end
            end
        end
    end

    // triggers: a write of one sets, zero is ignored; a new request wins
    // over the completion clear so a back-to-back request is not lost
    always_comb begin
        trig_set = 2'b00;
        if (i_reg_wr && i_reg_addr == ADDR_TRIGGER) begin
            trig_set[BIT_SENSOR_TRIG] = i_reg_wdata[BIT_SENSOR_TRIG];
            trig_set[BIT_OFFSET_TRIG] = i_reg_wdata[BIT_OFFSET_TRIG];
        end
        trig_clr = 2'b00;
        if (state_r == CSRC_NEXT && is_last_chan(chan_r) && !sleeping) begin
            trig_clr[BIT_OFFSET_TRIG] = mode_ofs_r;
            trig_clr[BIT_SENSOR_TRIG] = ~mode_ofs_r;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            trig_r <= 2'b00;
        end else if (i_ce) begin
            trig_r <= (trig_r & ~trig_clr) | trig_set; // RULE16
        end
    end

    // capture sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CSRC_IDLE: begin
                // offset first so a trimmed capture uses the fresh offset
                if (trig_r[BIT_OFFSET_TRIG]) begin
                    state_nxt = CSRC_SAMPLE; // RULE2
                end else if (trig_r[BIT_SENSOR_TRIG]) begin
                    state_nxt = CSRC_INTEG; // RULE1
                end
            end
            CSRC_INTEG: begin
                if (slot_cnt_r == int_r[chan_r]) begin
                    state_nxt = CSRC_SAMPLE;
                end
            end
            CSRC_SAMPLE: begin
                state_nxt = CSRC_NEXT;
            end
            CSRC_NEXT: begin
                if (is_last_chan(chan_r)) begin
                    state_nxt = CSRC_IDLE;
                end else begin
                    state_nxt = mode_ofs_r ? CSRC_SAMPLE : CSRC_INTEG;
                end
            end
            default: begin
                state_nxt = CSRC_IDLE;
            end
        endcase
    end

    // channel and mode of the coming cycle; the front end is driven from
    // these so the sample it returns belongs to the channel being stored
    always_comb begin
        chan_nxt = chan_r;
        mode_ofs_nxt = mode_ofs_r;
        if (state_r == CSRC_IDLE) begin
            chan_nxt = '0;
            mode_ofs_nxt = trig_r[BIT_OFFSET_TRIG];
        end else if (state_r == CSRC_NEXT) begin
            chan_nxt = chan_r + 2'h1;
        end
    end

    // sleep freezes the sequencer; pending triggers wait for wake-up
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= CSRC_IDLE;
            chan_r <= '0;
            mode_ofs_r <= 1'b0;
        end else if (i_ce && !sleeping) begin
            state_r <= state_nxt;
            chan_r <= chan_nxt;
            mode_ofs_r <= mode_ofs_nxt;
        end
    end

    // previous level of the external clock pin, for rising-edge detection
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ext_clk_d_r <= 1'b0;
        end else if (i_ce) begin
            ext_clk_d_r <= i_ext_clk;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            slot_cnt_r <= RST_INT;
        end else if (i_ce) begin
            if (state_r != CSRC_INTEG) begin
                slot_cnt_r <= RST_INT;
            end else if (!sleeping && slot_tick && slot_cnt_r != int_r[chan_r]) begin
                slot_cnt_r <= slot_cnt_r + 12'h001; // RULE10
            end
        end
    end

    // result and offset stores
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                out_r[i] <= RST_DATA;
                ofs_r[i] <= RST_OFS;
            end
        end else if (i_ce && !sleeping && state_r == CSRC_SAMPLE) begin
            if (mode_ofs_r) begin
                ofs_r[chan_r] <= sat_ofs(i_light_sample); // RULE2
            end else if (config_r[BIT_OFFSET_TRIM]) begin
                out_r[chan_r] <= sat_sub(i_light_sample, ofs_r[chan_r]); // RULE6
            end else begin
                out_r[chan_r] <= i_light_sample; // RULE1
            end
        end
    end

    // readback decode; unmapped addresses and reserved bits read zero
    always_comb begin
        rdata_nxt = 8'h00;
        case (i_reg_addr)
            ADDR_TRIGGER: rdata_nxt = {6'h00, trig_r};
            ADDR_CONFIG: rdata_nxt = config_r; // RULE4
            ADDR_LAMP: rdata_nxt = lamp_r;
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (is_cap_addr(i_reg_addr, i)) begin
                rdata_nxt = {4'h0, cap_r[i]}; // RULE12
            end
            if (is_int_lo_addr(i_reg_addr, i)) begin
                rdata_nxt = int_r[i][7:0];
            end
            if (is_int_hi_addr(i_reg_addr, i)) begin
                rdata_nxt = {4'h0, int_r[i][INT_W-1:8]};
            end
            if (is_out_lo_addr(i_reg_addr, i)) begin
                rdata_nxt = out_r[i][7:0]; // RULE12
            end
            if (is_out_hi_addr(i_reg_addr, i)) begin
                rdata_nxt = {6'h00, out_r[i][DATA_W-1:8]};
            end
            if (is_ofs_addr(i_reg_addr, i)) begin
                rdata_nxt = ofs_r[i]; // RULE12
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_nxt;
            end
        end
    end

    // pin-side outputs
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_use_ext_clk <= 1'b0;
            o_sleep <= 1'b0;
            o_lamp <= 1'b0;
        end else if (i_ce) begin
            o_use_ext_clk <= ext_sel; // RULE3
            o_sleep <= sleeping; // RULE5
            o_lamp <= lamp_r[BIT_LAMP_ON]
                | (lamp_r[BIT_LAMP_PIN_EN] & ext_sel & i_sleep_pin); // RULE7 RULE8
        end
    end

    // converter drive follows the sequencer's next step and freezes with it
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_busy <= 1'b0;
            o_front <= RST_FRONT;
        end else if (i_ce && !sleeping) begin
            o_busy <= (state_nxt != CSRC_IDLE);
            o_front.chan <= chan_nxt;
            o_front.gain_caps <= cap_r[chan_nxt]; // RULE9
            o_front.integrating <= (state_nxt == CSRC_INTEG);
            o_front.dark <= mode_ofs_nxt && state_nxt != CSRC_IDLE;
        end
    end

endmodule : csrc_top

//--- sim/csrc_front_model.sv
// Converter front end model for the colour sensor register block.
// Assumes the block samples the channel it names on o_front.
`timescale 1ns/100ps

module csrc_front_model
    import csrc_pkg::*;
(
    input wire csrc_front_s i_front,
    output logic [DATA_W-1:0] o_sample
);
    // dark level kept small so a trimmed reading stays above zero
    always_comb begin
        if (i_front.dark)
            o_sample = 10'h010 + 10'(i_front.chan);
        else
            o_sample = 10'h100 + {4'h0, i_front.chan, i_front.gain_caps};
    end
endmodule : csrc_front_model

//--- sim/csrc_properties.sv
// Port checks for the colour sensor register block.
// Assumes it is bound onto csrc_top.
`timescale 1ns/100ps

module csrc_properties
    import csrc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_use_ext_clk,
    input wire logic o_sleep,
    input wire logic o_lamp,
    input wire logic o_busy,
    input wire csrc_front_s o_front
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence s_wr(logic [7:0] a);
        i_ce && i_reg_wr && i_reg_addr == a;
    endsequence
    property p_lamp;
        s_wr(ADDR_LAMP) ##0 !i_reg_wdata[BIT_LAMP_PIN_EN]
            |-> ##2 o_lamp == $past(i_reg_wdata[BIT_LAMP_ON], 2);
    endproperty
    property p_ext;
        s_wr(ADDR_CONFIG) |-> ##2 o_use_ext_clk == $past(i_reg_wdata[BIT_EXT_CLK], 2);
    endproperty
    property p_sleep;
        o_sleep |-> o_use_ext_clk;
    endproperty
    property p_rd;
        i_ce && i_reg_rd |=> o_reg_rvalid;
    endproperty
    property p_nord;
        !(i_ce && i_reg_rd) |=> !o_reg_rvalid;
    endproperty
    property p_hold;
        !o_reg_rvalid |-> $stable(o_reg_rdata);
    endproperty
    property p_unmapped;
        i_ce && i_reg_rd && i_reg_addr == 8'h30 |=> o_reg_rdata == 8'h00;
    endproperty
    property p_busy;
        s_wr(ADDR_TRIGGER) ##0 i_reg_wdata[BIT_SENSOR_TRIG] && !o_busy && !o_sleep
            |-> ##[1:3] o_busy;
    endproperty
    property p_integ;
        o_front.integrating |-> o_busy && !o_front.dark;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp does not follow its bit");
    a_ext: assert property (p_ext) else $error("clock select does not follow");
    a_sleep: assert property (p_sleep) else $error("sleep without ext clock");
    a_rd: assert property (p_rd) else $error("read not answered");
    a_nord: assert property (p_nord) else $error("stray read valid");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_busy: assert property (p_busy) else $error("capture did not start");
    a_integ: assert property (p_integ) else $error("integrating while idle or dark");
endmodule : csrc_properties

bind csrc_top csrc_properties u_props (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_use_ext_clk(o_use_ext_clk), .o_sleep(o_sleep), .o_lamp(o_lamp), .o_busy(o_busy),
    .o_front(o_front));

//--- sim/testbench.sv
// Self-checking bench for the colour sensor register block.
// Assumes the front end model answers every sample request.
`timescale 1ns/100ps

module testbench
    import csrc_pkg::*;
;
    logic clk, reset, wr, rd, pin, rvalid, ext, slp, lamp, busy, xclk, xrun;
    logic [7:0] addr, wdata, rdata;
    logic [DATA_W-1:0] sample;
    csrc_front_s front;
    int bad_count = 0;
    int n_compared = 0;

    csrc_top uut (.i_clk(clk), .i_reset(reset), .i_ce(1'b1), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_ext_clk(xclk), .i_sleep_pin(pin),
        .i_light_sample(sample), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .o_use_ext_clk(ext), .o_sleep(slp), .o_lamp(lamp), .o_busy(busy), .o_front(front));
    csrc_front_model u_model (.i_front(front), .o_sample(sample));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // external clock pin: one rising edge every two cycles while running
    always @(posedge clk) xclk <= xrun && !xclk;

    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_get(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_get

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd_get(a, d);
        check("rvalid", 10'h001, 10'(rvalid));
        check(what, 10'(exp), 10'(d));
    endtask : rd_chk

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    // polls the trigger byte, which clears itself when the capture ends
    task automatic wait_idle;
        int n;
        logic [7:0] d;
        d = 8'hFF;
        for (n = 0; n < 300; n++) begin
            rd_get(ADDR_TRIGGER, d);
            if (d === 8'h00)
                break;
        end
        check("capture ended", 10'h000, 10'(d));
        if (d !== 8'h00)
            summarize();
    endtask : wait_idle

    task automatic t_regs;
        rd_chk(ADDR_CONFIG, 8'h00, "config reset");
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_CAP_BASE + 8'(i), 8'hFF);
            wr_reg(ADDR_INT_BASE + 8'(2 * i), 8'hFF);
            wr_reg(ADDR_INT_BASE + 8'(2 * i + 1), 8'hFF);
        end
        for (int i = 0; i < 4; i++) begin
            rd_chk(ADDR_CAP_BASE + 8'(i), 8'h0F, "caps");
            rd_chk(ADDR_INT_BASE + 8'(2 * i), 8'hFF, "int lo");
            rd_chk(ADDR_INT_BASE + 8'(2 * i + 1), 8'h0F, "int hi");
        end
        rd_chk(8'h30, 8'h00, "unmapped");
        wr_reg(ADDR_OUT_BASE, 8'h55);
        rd_chk(ADDR_OUT_BASE, 8'h00, "output ro");
        $display("test regs done");
    endtask : t_regs

    task automatic t_ctrl;
        wr_reg(ADDR_CONFIG, 8'h04);
        settle();
        check("ext clock", 10'h001, 10'(ext));
        rd_chk(ADDR_CONFIG, 8'h04, "config");
        wr_reg(ADDR_CONFIG, 8'h06);
        settle();
        check("sleep on", 10'h001, 10'(slp));
        wr_reg(ADDR_CONFIG, 8'h02);
        settle();
        check("sleep internal", 10'h000, 10'(slp));
        wr_reg(ADDR_LAMP, 8'h01);
        settle();
        check("lamp on", 10'h001, 10'(lamp));
        wr_reg(ADDR_LAMP, 8'h00);
        settle();
        check("lamp off", 10'h000, 10'(lamp));
        wr_reg(ADDR_CONFIG, 8'h04);
        wr_reg(ADDR_LAMP, 8'h02);
        @(posedge clk) pin <= 1'b1;
        settle();
        check("pin lamp", 10'h001, 10'(lamp));
        @(posedge clk) pin <= 1'b0;
        settle();
        check("pin lamp low", 10'h000, 10'(lamp));
        wr_reg(ADDR_CONFIG, 8'h00);
        @(posedge clk) pin <= 1'b1;
        settle();
        check("pin internal", 10'h000, 10'(lamp));
        wr_reg(ADDR_LAMP, 8'h00);
        $display("test ctrl done");
    endtask : t_ctrl

    task automatic grab(input logic trim);
        logic [9:0] e;
        wr_reg(ADDR_TRIGGER, 8'h01);
        wait_idle();
        for (int i = 0; i < 4; i++) begin
            e = 10'h10F + 10'(16 * i) - (trim ? 10'h010 + 10'(i) : 10'h000);
            rd_chk(ADDR_OUT_BASE + 8'(2 * i), e[7:0], "out lo");
            rd_chk(ADDR_OUT_BASE + 8'(2 * i + 1), {6'h00, e[9:8]}, "out hi");
        end
    endtask : grab

    task automatic t_cap;
        for (int i = 0; i < 8; i++)
            wr_reg(ADDR_INT_BASE + 8'(i), 8'h00);
        wr_reg(ADDR_TRIGGER, 8'h02);
        wait_idle();
        for (int i = 0; i < 4; i++)
            rd_chk(ADDR_OFS_BASE + 8'(i), 8'h10 + 8'(i), "offset");
        grab(1'b0);
        wr_reg(ADDR_CONFIG, 8'h01);
        grab(1'b1);
        $display("test capture done");
    endtask : t_cap

    task automatic t_ext;
        // calibration-style sweep, capped far below the field limit
        for (int t = 0; t < 3; t++)
            for (int i = 0; i < 4; i++)
                wr_reg(ADDR_INT_BASE + 8'(2 * i), 8'(t));
        wr_reg(ADDR_CONFIG, 8'h04);
        wr_reg(ADDR_TRIGGER, 8'h01);
        repeat (20) @(posedge clk);
        #1;
        check("busy without slots", 10'h001, 10'(busy));
        rd_chk(ADDR_TRIGGER, 8'h01, "stalled trigger");
        xrun <= 1'b1;
        grab(1'b0);
        $display("test ext clock done");
    endtask : t_ext

    initial begin
        reset = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        pin = 1'b0;
        xrun = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_ctrl();
        t_cap();
        t_ext();
        summarize();
    end
endmodule : testbench
